/* hw/fsc_pkg.sv */
package fsc_pkg;

  // clock and pin timing
  localparam int CLK_NS = 4;
  localparam int T_RD_NS = 70;
  localparam int T_WP_NS = 50;
  localparam int T_REC_NS = 30;
  localparam int T_PLPH_NS = 100;
  localparam int T_PHWL_NS = 150;
  localparam int RD_CYC = (T_RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int REC_CYC = (T_REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int PLPH_CYC = (T_PLPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int PHWL_CYC = (T_PHWL_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC = 2;
  localparam int CNT_W = 8;

  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // control fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W = 4;
  localparam int CTRL_AUTO_BIT = 4;

  // status register fields
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_SUSP_BIT = 9;
  localparam int STAT_REFUSED_BIT = 10;
  localparam int STAT_RESET_BIT = 11;

  // operations
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_READ = 4'h1;
  localparam logic [3:0] OP_RAW = 4'h2;
  localparam logic [3:0] OP_PROGRAM = 4'h3;
  localparam logic [3:0] OP_ERASE = 4'h4;
  localparam logic [3:0] OP_STATUS = 4'h5;
  localparam logic [3:0] OP_CLEAR = 4'h6;
  localparam logic [3:0] OP_QUERY = 4'h7;
  localparam logic [3:0] OP_ARRAY = 4'h8;
  localparam logic [3:0] OP_SUSPEND = 4'h9;
  localparam logic [3:0] OP_RESUME = 4'ha;
  localparam logic [3:0] OP_RESET = 4'hb;

  // device command codes
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [7:0] CMD_ARRAY = 8'hff;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'hd0;

  // device status bits
  localparam int ST_READY = 7;
  localparam int ST_SUSP = 2;
  localparam logic [7:0] STATUS_RESET = 8'h80;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : fsc_pkg

/* hw/fsc_bus_cycle.sv */
`timescale 1ns/1ns
module fsc_bus_cycle
  import fsc_pkg::*;
#(
  parameter int AW = 22,
  parameter int DW = 16
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // request
  input wire logic start,
  input wire logic is_write,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic done,
  output logic [DW-1:0] rdata,
  // flash pins
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [AW-1:0] flash_addr,
  output logic [DW-1:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [DW-1:0] flash_dq_i
);

  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_ACTIVE, CY_RECOVER} fsc_cyc_t;

  fsc_cyc_t state;
  logic wr;
  logic [CNT_W-1:0] cnt;
  logic [DW-1:0] dq_meta;
  logic [DW-1:0] dq_sync;

  if (RD_CYC + SYNC_CYC >= 2 ** CNT_W || WP_CYC >= 2 ** CNT_W || REC_CYC >= 2 ** CNT_W)
  begin : g_bad_cnt
    $error("fsc_bus_cycle: timing count too wide");
  end

  // data pins pass two flip-flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dq_meta <= '0;
      dq_sync <= '0;
    end
    else
    begin
      dq_meta <= flash_dq_i;
      dq_sync <= dq_meta;
    end
  end

  // one strobe cycle on the pins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= CY_IDLE;
      wr <= 1'b0;
      cnt <= '0;
      done <= 1'b0;
      rdata <= '0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_addr <= '0;
      flash_dq_o <= '0;
      flash_dq_oe <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        CY_IDLE:
          if (start)
          begin
            flash_addr <= addr;
            flash_dq_o <= wdata;
            flash_dq_oe <= is_write;
            wr <= is_write;
            flash_ce_n <= 1'b0;
            state <= CY_SETUP;
          end
        CY_SETUP:
        begin
          if (wr)
          begin
            flash_we_n <= 1'b0;
            cnt <= CNT_W'(WP_CYC - 1);
          end
          else
          begin
            flash_oe_n <= 1'b0;
            cnt <= CNT_W'(RD_CYC + SYNC_CYC - 1);
          end
          state <= CY_ACTIVE;
        end
        CY_ACTIVE:
          if (cnt == '0)
          begin
            if (!wr)
              rdata <= dq_sync;
            // write strobe and select rise together
            flash_we_n <= 1'b1;
            // every read ends with both strobes high
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            cnt <= CNT_W'(REC_CYC - 1);
            state <= CY_RECOVER;
          end
          else
            cnt <= cnt - 1'b1;
        CY_RECOVER:
          if (cnt == '0)
          begin
            flash_dq_oe <= 1'b0;
            done <= 1'b1;
            state <= CY_IDLE;
          end
          else
            cnt <= cnt - 1'b1;
        default:
          state <= CY_IDLE;
      endcase
    end
  end

endmodule : fsc_bus_cycle

/* hw/fsc_flash_ctrl.sv */
`timescale 1ns/1ns
// Overview of operation
// - host toggles select or output-enable for every status poll
// - program is setup 0x40 then a write with address and data
// - host keeps reset/power-down deasserted during program suspend
// - erase is setup then confirm; block address taken at confirm
// - host clears status with 0x50 and returns to array mode
// - erase setup 0x20, confirm 0xD0 at the block address
module fsc_flash_ctrl
  import fsc_pkg::*;
#(
  parameter int AW = 22,
  parameter int DW = 16
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // flash pins
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [AW-1:0] flash_addr,
  output logic [DW-1:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [DW-1:0] flash_dq_i,
  output logic reset_powerdown_n
);

  typedef enum logic [2:0] {M_RST_LOW, M_RST_WAIT, M_IDLE, M_ISSUE, M_WAIT} fsc_state_t;
  typedef enum logic [1:0] {K_END, K_WR, K_RD, K_POLL} fsc_kind_t;

  if (AW < 1 || AW > 32 || DW != 16 || PLPH_CYC >= 2 ** CNT_W || PHWL_CYC >= 2 ** CNT_W)
  begin : g_bad_param
    $error("fsc_flash_ctrl: unsupported parameters");
  end

  fsc_state_t state;
  fsc_kind_t pl_kind;
  logic [DW-1:0] pl_data;
  logic [3:0] op;
  logic [2:0] step;
  logic [CNT_W-1:0] timer;
  logic auto_clean;
  logic [AW-1:0] addr_reg;
  logic [DW-1:0] wdata_reg;
  logic [DW-1:0] rdata_reg;
  logic [7:0] dev_status;
  logic suspended;
  logic refused;
  logic cyc_start;
  logic cyc_done;
  logic [DW-1:0] cyc_rdata;
  logic wr_fire;
  logic rd_fire;
  logic wr_map;
  logic ctrl_wr;
  logic [3:0] new_op;
  logic op_ok;
  logic launch;
  logic [31:0] next_rdata;
  logic rd_map;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction : merge

  // bus handshakes
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign rd_fire = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_map = s_axi_awaddr == REG_CTRL || s_axi_awaddr == REG_ADDR || s_axi_awaddr == REG_WDATA;
  assign ctrl_wr = wr_fire && s_axi_awaddr == REG_CTRL && s_axi_wstrb[0];
  assign new_op = s_axi_wdata[CTRL_OP_LSB +: CTRL_OP_W];

  // while suspended only the reads, resume and array return may go
  // reset is withheld during suspend
  always_comb
  begin
    if (suspended)
      op_ok = new_op == OP_READ || new_op == OP_STATUS || new_op == OP_QUERY ||
              new_op == OP_ARRAY || new_op == OP_RESUME;
    else
      op_ok = new_op != OP_NONE && new_op <= OP_RESET;
  end
  assign launch = ctrl_wr && state == M_IDLE && op_ok;

  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_map ? RESP_OKAY : RESP_DECERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // software registers, held steady while a sequence runs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      addr_reg <= '0;
      wdata_reg <= '0;
      auto_clean <= 1'b1;
      op <= OP_NONE;
    end
    else if (wr_fire && state == M_IDLE)
    begin
      if (s_axi_awaddr == REG_ADDR)
        addr_reg <= AW'(merge(32'(addr_reg), s_axi_wdata, s_axi_wstrb));
      if (s_axi_awaddr == REG_WDATA)
        wdata_reg <= DW'(merge(32'(wdata_reg), s_axi_wdata, s_axi_wstrb));
      if (launch)
      begin
        op <= new_op;
        auto_clean <= s_axi_wdata[CTRL_AUTO_BIT];
      end
    end
  end

  // refused order flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      refused <= 1'b0;
    else if (ctrl_wr)
      refused <= !launch;
  end

  // read channel
  assign rd_map = s_axi_araddr == REG_CTRL || s_axi_araddr == REG_ADDR || s_axi_araddr == REG_WDATA ||
                  s_axi_araddr == REG_RDATA || s_axi_araddr == REG_STATUS;
  always_comb
  begin
    next_rdata = '0;
    case (s_axi_araddr)
      REG_CTRL:
      begin
        next_rdata[CTRL_OP_LSB +: CTRL_OP_W] = op;
        next_rdata[CTRL_AUTO_BIT] = auto_clean;
      end
      REG_ADDR: next_rdata = 32'(addr_reg);
      REG_WDATA: next_rdata = 32'(wdata_reg);
      REG_RDATA: next_rdata = 32'(rdata_reg);
      REG_STATUS:
      begin
        next_rdata[7:0] = dev_status;
        next_rdata[STAT_BUSY_BIT] = state != M_IDLE;
        next_rdata[STAT_SUSP_BIT] = suspended;
        next_rdata[STAT_REFUSED_BIT] = refused;
        next_rdata[STAT_RESET_BIT] = !reset_powerdown_n;
      end
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= rd_map ? RESP_OKAY : RESP_DECERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // bus cycles of each sequence
  always_comb
  begin
    pl_kind = K_END;
    pl_data = '0;
    case (op)
      OP_PROGRAM, OP_ERASE:
        case (step)
          3'd0:
          begin
            pl_kind = K_WR;
            pl_data[7:0] = op == OP_PROGRAM ? CMD_PROGRAM : CMD_ERASE;
          end
          3'd1:
          begin
            pl_kind = K_WR;
            // data bits left at 1 leave cells untouched
            pl_data = op == OP_PROGRAM ? wdata_reg : {8'h00, CMD_CONFIRM};
          end
          3'd2: pl_kind = K_POLL;
          3'd3:
          begin
            pl_kind = auto_clean ? K_WR : K_END;
            pl_data[7:0] = CMD_CLEAR;
          end
          3'd4:
          begin
            pl_kind = auto_clean ? K_WR : K_END;
            pl_data[7:0] = CMD_ARRAY;
          end
          default: pl_kind = K_END;
        endcase
      OP_STATUS, OP_QUERY:
        if (step == 3'd0)
        begin
          pl_kind = K_WR;
          pl_data[7:0] = op == OP_STATUS ? CMD_STATUS : CMD_QUERY;
        end
        else if (step == 3'd1)
          pl_kind = K_RD;
      OP_SUSPEND:
        if (step == 3'd0)
        begin
          pl_kind = K_WR;
          pl_data[7:0] = CMD_SUSPEND;
        end
        else if (step == 3'd1)
          pl_kind = K_POLL;
      OP_CLEAR, OP_ARRAY, OP_RESUME, OP_RAW:
        if (step == 3'd0)
        begin
          pl_kind = K_WR;
          case (op)
            OP_CLEAR: pl_data[7:0] = CMD_CLEAR;
            OP_ARRAY: pl_data[7:0] = CMD_ARRAY;
            OP_RESUME: pl_data[7:0] = CMD_RESUME;
            default: pl_data = wdata_reg;
          endcase
        end
      OP_READ:
        if (step == 3'd0)
          pl_kind = K_RD;
      default: pl_kind = K_END;
    endcase
  end

  // sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= M_RST_LOW;
      step <= '0;
      timer <= CNT_W'(PLPH_CYC - 1);
      cyc_start <= 1'b0;
    end
    else
    begin
      cyc_start <= 1'b0;
      case (state)
        M_RST_LOW:
          if (timer == '0)
          begin
            timer <= CNT_W'(PHWL_CYC - 1);
            state <= M_RST_WAIT;
          end
          else
            timer <= timer - 1'b1;
        M_RST_WAIT:
          if (timer == '0)
            state <= M_IDLE;
          else
            timer <= timer - 1'b1;
        M_IDLE:
          if (launch)
          begin
            step <= '0;
            if (new_op == OP_RESET)
            begin
              timer <= CNT_W'(PLPH_CYC - 1);
              state <= M_RST_LOW;
            end
            else
              state <= M_ISSUE;
          end
        M_ISSUE:
          if (pl_kind == K_END)
            state <= M_IDLE;
          else
          begin
            cyc_start <= 1'b1;
            state <= M_WAIT;
          end
        M_WAIT:
          if (cyc_done)
          begin
            // poll with a fresh strobe until the device is ready
            if (!(pl_kind == K_POLL && !cyc_rdata[ST_READY]))
              step <= step + 1'b1;
            state <= M_ISSUE;
          end
        default:
          state <= M_IDLE;
      endcase
    end
  end

  // reset pin, low during our reset and the reset order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reset_powerdown_n <= 1'b0;
    else
      reset_powerdown_n <= state != M_RST_LOW;
  end

  // captured answers from the device
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rdata_reg <= '0;
      dev_status <= STATUS_RESET;
    end
    else if (state == M_RST_LOW)
      dev_status <= STATUS_RESET;
    else if (state == M_WAIT && cyc_done && (pl_kind == K_RD || pl_kind == K_POLL))
    begin
      rdata_reg <= cyc_rdata;
      // status bits from every poll and from the status order
      if (pl_kind == K_POLL || op == OP_STATUS)
        dev_status <= cyc_rdata[7:0];
    end
  end

  // suspend tracking
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      suspended <= 1'b0;
    else if (state == M_WAIT && cyc_done && op == OP_SUSPEND && pl_kind == K_POLL)
      suspended <= cyc_rdata[ST_READY] && cyc_rdata[ST_SUSP];
    else if (state == M_WAIT && cyc_done && op == OP_RESUME)
      suspended <= 1'b0;
  end

  fsc_bus_cycle #(
    .AW(AW),
    .DW(DW)
  ) u_cycle (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(cyc_start),
    .is_write(pl_kind == K_WR),
    .addr(addr_reg),
    .wdata(pl_data),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_i(flash_dq_i)
  );

endmodule : fsc_flash_ctrl

/* dv/fsc_flash_model.sv */
`timescale 1ns/1ns
module fsc_flash_model #(
  parameter int AW = 22,
  parameter int POLLS = 3,
  parameter int BLK_W = 15,
  parameter logic [15:0] QRY_WORD = 16'h005a
)
(
  // flash pins
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [AW-1:0] flash_addr,
  input wire logic [15:0] flash_dq_o,
  input wire logic reset_powerdown_n,
  // fault injection and read data
  input wire logic fail_op,
  output logic [15:0] flash_dq_i
);
  logic [15:0] mem [int];
  logic [15:0] val = 16'h0000;
  logic [7:0] sr;
  logic [AW-1:0] wa;
  logic susp, armed, locked, erase_op;
  int mode, pend, busy;
  // released bus shows the inverse of the last word, never a stale copy
  assign flash_dq_i = (!flash_ce_n && !flash_oe_n) ? val : ~val;
  always @(reset_powerdown_n)
    if (!reset_powerdown_n)
    begin
      sr = 8'h80;
      {mode, pend, busy, susp, locked} = {96'h0, 2'h1};
    end
  task automatic start_op(input logic e, input logic [AW-1:0] a);
    erase_op = e;
    wa = a;
    busy = POLLS;
    sr[7] = 1'b0;
  endtask : start_op
  task automatic finish_op();
    sr[7] = 1'b1;
    if (fail_op)
      sr = sr | (erase_op ? 8'h20 : 8'h10);
    else if (erase_op)
      foreach (mem[k])
        if ((k >> BLK_W) == (wa >> BLK_W))
          mem[k] = 16'hffff;
  endtask : finish_op
  task automatic command(input logic [AW-1:0] a, input logic [15:0] d);
    logic [7:0] c;
    c = d[7:0];
    if (busy > 0 && !susp)
    begin
      susp = (c == 8'hb0);
      sr[7] = susp;
      sr[2] = susp;
    end
    else if (susp)
    begin
      susp = (c != 8'hd0);
      sr[7] = susp;
      sr[2] = susp;
      mode = (c == 8'hff) ? 0 : (c == 8'h98) ? 1 : 2;
    end
    else if (pend == 0)
    begin
      pend = (c == 8'h40) ? 1 : (c == 8'h20) ? 2 : (c == 8'h60) ? 3 : 0;
      mode = (c == 8'hff) ? 0 : (c == 8'h98) ? 1 : (c == 8'h70) ? 2 : mode;
      if (c == 8'h50)
        sr = sr & 8'hc5;
    end
    else
    begin
      mode = (pend == 3) ? mode : 2;
      if (pend == 3)
        locked = (c != 8'hd0);
      else if (pend == 2 && c == 8'hd0)
        start_op(1'b1, a);
      else if (pend == 2)
        sr[5:4] = 2'b11;
      else if (locked)
        sr[1] = 1'b1;
      else
      begin
        mem[a] = (mem.exists(a) ? mem[a] : 16'hffff) & d;
        start_op(1'b0, a);
      end
      pend = 0;
    end
  endtask : command
  // status snapshot at the later falling edge of select and output-enable
  always @(negedge flash_oe_n or negedge flash_ce_n)
    if (!flash_oe_n && !flash_ce_n)
    begin
      if (busy > 0 && !susp)
        busy--;
      if (busy == 0 && !sr[7] && !susp)
        finish_op();
      if (mode == 2 || busy > 0)
        val = {8'h00, sr};
      else if (mode == 1)
        val = QRY_WORD;
      else
        val = mem.exists(flash_addr) ? mem[flash_addr] : 16'hffff;
    end
  always @(negedge flash_we_n)
    armed = !flash_ce_n;
  always @(posedge flash_we_n or posedge flash_ce_n)
    if (armed)
    begin
      armed = 1'b0;
      command(flash_addr, flash_dq_o);
    end
endmodule : fsc_flash_model

/* dv/fsc_flash_ctrl_props.sv */
`timescale 1ns/1ns
module fsc_flash_ctrl_props
  import fsc_pkg::*;
#(
  parameter int AW = 22,
  parameter int DW = 16
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // flash pins
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [AW-1:0] flash_addr,
  input wire logic [DW-1:0] flash_dq_o,
  input wire logic flash_dq_oe,
  input wire logic reset_powerdown_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  endsequence
  sequence we_held;
    !flash_we_n && !flash_ce_n && flash_oe_n && flash_dq_oe && $stable(flash_addr) && $stable(flash_dq_o);
  endsequence
  wr_answer_a: assert property (wr_take |=> s_axi_bvalid)
    else $error("write answer missing");
  aw_gate_a: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
    else $error("write ready wrong");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  we_width_a: assert property ($fell(flash_we_n) |-> we_held [*8])
    else $error("write strobe too short");
  poll_fresh_a: assert property ($rose(flash_oe_n) |-> $rose(flash_ce_n))
    else $error("read strobe not closed");
  rp_hold_a: assert property ($rose(aresetn) |-> !reset_powerdown_n [*8])
    else $error("reset pin pulse short");
  oe_quiet_a: assert property (!flash_oe_n |-> !flash_dq_oe && !flash_ce_n)
    else $error("bus clash on read");
endmodule : fsc_flash_ctrl_props
bind fsc_flash_ctrl fsc_flash_ctrl_props #(.AW(AW), .DW(DW)) i_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr, .flash_dq_o, .flash_dq_oe, .reset_powerdown_n
);

/* dv/tb_fsc_flash_ctrl.sv */
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module tb_fsc_flash_ctrl
  import fsc_pkg::*;
;
  localparam logic [15:0] QRY = 16'h005a;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, fail_op = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, st;
  logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe, reset_powerdown_n;
  logic [21:0] flash_addr;
  logic [15:0] flash_dq_o, flash_dq_i;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  fsc_flash_ctrl i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr, .flash_dq_o, .flash_dq_oe, .flash_dq_i,
    .reset_powerdown_n
  );
  fsc_flash_model #(.QRY_WORD(QRY)) i_mdl (
    .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr, .flash_dq_o, .reset_powerdown_n, .fail_op, .flash_dq_i
  );
  initial
  begin
    forever #2 aclk = ~aclk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_left;
    logic w_left;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_left = 1'b1;
    w_left = 1'b1;
    // each channel is released at the edge its own ready is seen
    while (aw_left || w_left)
    begin
      @(posedge aclk);
      if (aw_left && s_axi_awready === 1'b1)
      begin
        aw_left = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_left && s_axi_wready === 1'b1)
      begin
        w_left = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic launch(input logic [3:0] code, input logic au);
    wr(REG_CTRL, {27'h0, au, code}, rsp);
  endtask : launch
  task automatic idle();
    do rd(REG_STATUS, st, rsp); while (st[STAT_BUSY_BIT] !== 1'b0);
  endtask : idle
  task automatic op(input logic [3:0] code);
    launch(code, 1'b1);
    idle();
  endtask : op
  task automatic raw(input logic [15:0] d);
    wr(REG_WDATA, {16'h0, d}, rsp);
    op(OP_RAW);
  endtask : raw
  task automatic rdword(input logic [15:0] w);
    op(OP_READ);
    rd(REG_RDATA, st, rsp);
    `CHK("array word", {16'h0, w}, st)
  endtask : rdword
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(REG_STATUS, st, rsp);
    `CHK("reset pin", 2'b10, {st[STAT_RESET_BIT], reset_powerdown_n})
    idle();
    `CHK("status at reset", 8'h80, st[7:0])
    rd(8'h14, st, rsp);
    `CHK("unmapped read", {RESP_DECERR, 32'h0}, {rsp, st})
    wr(8'h18, 32'h0, rsp);
    `CHK("unmapped write", RESP_DECERR, rsp)
    wr(REG_ADDR, 32'h100, rsp);
    op(OP_QUERY);
    rd(REG_RDATA, st, rsp);
    `CHK("query word", {16'h0, QRY}, st)
    op(OP_ARRAY);
    wr(REG_WDATA, 32'h12f4, rsp);
    launch(OP_PROGRAM, 1'b0);
    idle();
    `CHK("locked program", 8'h82, st[7:0])
    fail_op <= 1'b1;
    launch(OP_ERASE, 1'b0);
    idle();
    `CHK("errors add up", 8'ha2, st[7:0])
    fail_op <= 1'b0;
    op(OP_CLEAR);
    op(OP_STATUS);
    rd(REG_RDATA, st, rsp);
    `CHK("cleared status", 32'h80, st)
    raw(16'h0060);
    raw(16'h00d0);
    wr(REG_WDATA, 32'h12f4, rsp);
    launch(OP_PROGRAM, 1'b1);
    launch(OP_STATUS, 1'b1);
    rd(REG_STATUS, st, rsp);
    `CHK("busy refusal", 2'b11, {st[STAT_REFUSED_BIT], st[STAT_BUSY_BIT]})
    idle();
    `CHK("program done", 8'h80, st[7:0])
    wr(REG_WDATA, 32'hff0f, rsp);
    op(OP_PROGRAM);
    rdword(16'h1204);
    op(OP_ERASE);
    rdword(16'hffff);
    raw(16'h0020);
    raw(16'h0000);
    op(OP_STATUS);
    rd(REG_RDATA, st, rsp);
    `CHK("bad confirm", 32'hb0, st)
    op(OP_CLEAR);
    raw(16'h0040);
    raw(16'h0ff0);
    op(OP_SUSPEND);
    `CHK("suspended", 9'h184, {st[STAT_SUSP_BIT], st[7:0]})
    launch(OP_RESET, 1'b1);
    rd(REG_STATUS, st, rsp);
    `CHK("no reset in suspend", 2'b11, {reset_powerdown_n, st[STAT_REFUSED_BIT]})
    op(OP_RESUME);
    op(OP_STATUS);
    `CHK("resumed", 8'h00, st[7:0])
    op(OP_STATUS);
    op(OP_STATUS);
    `CHK("finished", 8'h80, st[7:0])
    op(OP_ARRAY);
    rdword(16'h0ff0);
    raw(16'h0020);
    raw(16'h0000);
    launch(OP_RESET, 1'b1);
    rd(REG_STATUS, st, rsp);
    `CHK("reset order", 2'b11, {st[STAT_RESET_BIT], st[STAT_BUSY_BIT]})
    idle();
    op(OP_STATUS);
    rd(REG_RDATA, st, rsp);
    `CHK("errors gone after reset", 32'h80, st)
    final_report();
  end
endmodule : tb_fsc_flash_ctrl
